// File: hw/vasfi_top.sv
// Auxiliary video path: smooth scroll, soft font load, bitmap and italic.
//
// Behaviour
// - Each row starts with a blanked dummy character; shrinking it scrolls left.
// - Once fully scrolled, unlink the leftmost character and restore full dummy width.
// - Blank is delayed by four bus clock stages, sixteen dots.
// - Force a blank one into shift position twelve for the dummy character.
// - Parallel input reads all ones while the character clock is high.
// - Pixels are negative logic; reverse is active at the serializer.
// - At most one font slice is written per row, triggered by the dummy.
// - The dummy character code selects the font character written.
// - Slice pattern is the upper eight bits of the row attribute.
// - Font write only when the dummy's cursor attribute bit is set.
// - Bitmap mode feeds the inverted character code to the shift register.
// - Row attribute bit 1 set selects bitmap mode; clear selects fonts.
// - Italic lookup is indexed by scan line and divide ratio.
// - Ratios four to twelve pass through unchanged.
// - Blank with width code 0000 or 1110 turns italic on.
// - Blank with width code 0001 or 1111 turns italic off.
// - Italic control widths vary with scan line: wide top or wide bottom.
// - Italic mode clears at the end of every row.
// - Italic control characters average the standard character width.
// - Bus and character clocks derive from the dot clock, resynced in blanking.
// - Character clock periods span four to twelve dots.
//
// Implementation choices: the Wishbone register port and the placing of the registers.
module vasfi_top (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   hblank_i,
  input  wire logic                   vsync_i,
  input  wire logic                   blank_i,
  input  wire vasfi_pkg::vasfi_char_t char_i,
  input  wire logic [9:0]             row_attr_i,
  input  wire logic [3:0]             scan_line_i,
  input  wire logic [3:0]             ratio_i,
  input  wire logic [7:0]             font_data_i,
  input  wire logic                   ser_video_i,
  output logic                        bus_clock_out_o,
  output logic                        character_clock_out_o,
  output logic      [3:0]             ser_width_o,
  output logic      [11:0]            ser_par_o,
  output logic                        ser_reverse_o,
  output logic                        video_o,
  output vasfi_pkg::vasfi_font_wr_t   font_wr_o,
  output logic                        unlink_o,
  output logic                        italic_o
);

  typedef struct packed {
    logic                      ack;
    logic [31:0]               rdata;
    logic [3:0]                step;
    logic                      scroll_en;
    logic [3:0]                dummy_full;
    logic [3:0]                shrink;
    logic                      unlink;
    logic [1:0]                bus_cnt;
    logic                      bus_clk;
    logic [3:0]                dot_cnt;
    logic [3:0]                width;
    logic                      char_clk;
    logic [11:0]               par;
    logic [3:0]                ser_width;
    logic                      italic;
    logic                      row_loaded;
    logic [7:0]                loads;
    vasfi_pkg::vasfi_font_wr_t fw;
    logic                      video;
  } vasfi_state_t;

  vasfi_state_t st_reg;
  vasfi_state_t st_next;

  logic       blank_dly;
  logic       bus_tick;
  logic [3:0] lut_width;
  logic [3:0] dummy_width;
  logic [3:0] scroll_room;
  logic [4:0] shrink_sum;
  logic       is_ital_on;
  logic       is_ital_off;
  logic       bitmap_mode;
  logic       char_end;
  logic       wb_req;

  // Italic width lookup, addressed by {scan line, divide ratio}.
  function automatic logic [3:0] vasfi_italic_lut(input logic [3:0] scan,
                                                  input logic [3:0] ratio);
    logic [3:0] w;
    w = ratio;
    unique case (ratio)
      vasfi_pkg::W_ITAL_ON9:  w = (scan < vasfi_pkg::ITAL_SPLIT9) ?
                                  vasfi_pkg::W_NINE + 4'h1 : vasfi_pkg::W_NINE - 4'h1;
      vasfi_pkg::W_ITAL_OFF9: w = (scan < vasfi_pkg::ITAL_SPLIT9) ?
                                  vasfi_pkg::W_NINE - 4'h1 : vasfi_pkg::W_NINE + 4'h1;
      vasfi_pkg::W_ITAL_ON6:  w = (scan < vasfi_pkg::ITAL_SPLIT6) ?
                                  vasfi_pkg::W_SIX + 4'h1 : vasfi_pkg::W_SIX - 4'h1;
      vasfi_pkg::W_ITAL_OFF6: w = (scan < vasfi_pkg::ITAL_SPLIT6) ?
                                  vasfi_pkg::W_SIX - 4'h1 : vasfi_pkg::W_SIX + 4'h1;
      default: begin
        if (ratio < vasfi_pkg::CHAR_MIN_DOTS || ratio > vasfi_pkg::CHAR_MAX_DOTS) begin
          w = vasfi_pkg::CHAR_MAX_DOTS;
        end else begin
          w = ratio;
        end
      end
    endcase
    return w;
  endfunction

  assign wb_req      = wb_cyc_i && wb_stb_i && !st_reg.ack;
  assign bus_tick    = (st_reg.bus_cnt == vasfi_pkg::BUS_DIV_LAST);
  assign lut_width   = vasfi_italic_lut(scan_line_i, ratio_i);
  assign scroll_room = st_reg.dummy_full - vasfi_pkg::CHAR_MIN_DOTS;
  assign shrink_sum  = {1'b0, st_reg.shrink} + {1'b0, st_reg.step};
  assign dummy_width = st_reg.dummy_full - st_reg.shrink;
  assign bitmap_mode = row_attr_i[vasfi_pkg::ROW_BITMAP_BIT];
  assign char_end    = (st_reg.dot_cnt == st_reg.width - 4'h1);
  assign is_ital_on  = (char_i.code == vasfi_pkg::CODE_BLANK) &&
                       (ratio_i == vasfi_pkg::W_ITAL_ON9 || ratio_i == vasfi_pkg::W_ITAL_ON6);
  assign is_ital_off = (char_i.code == vasfi_pkg::CODE_BLANK) &&
                       (ratio_i == vasfi_pkg::W_ITAL_OFF9 || ratio_i == vasfi_pkg::W_ITAL_OFF6);

  // Blank delay line, stepped once per bus clock period.
  vasfi_dly #(
    .STAGES (vasfi_pkg::BLANK_STAGES)
  ) u_blank_dly (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (bus_tick),
    .d_i    (blank_i),
    .q_o    (blank_dly)
  );

  always_comb begin
    st_next        = st_reg;
    st_next.unlink = 1'b0;
    st_next.fw.we  = 1'b0;

    // Wishbone slave: one wait state, answer to any address.
    st_next.ack = wb_req;
    if (wb_req) begin
      st_next.rdata = 32'h0000_0000;
      unique case (wb_adr_i)
        vasfi_pkg::OFS_CTRL: begin
          st_next.rdata[vasfi_pkg::CTRL_EN_BIT:0] = {st_reg.scroll_en, st_reg.step};
          if (wb_we_i && wb_sel_i[0]) begin
            st_next.step      = wb_dat_i[vasfi_pkg::CTRL_STEP_LSB +: 4];
            st_next.scroll_en = wb_dat_i[vasfi_pkg::CTRL_EN_BIT];
          end
        end
        vasfi_pkg::OFS_DUMMY: begin
          st_next.rdata[3:0] = st_reg.dummy_full;
          if (wb_we_i && wb_sel_i[0]) begin
            if (wb_dat_i[3:0] < vasfi_pkg::CHAR_MIN_DOTS ||
                wb_dat_i[3:0] > vasfi_pkg::CHAR_MAX_DOTS) begin
              st_next.dummy_full = vasfi_pkg::CHAR_MAX_DOTS;
            end else begin
              st_next.dummy_full = wb_dat_i[3:0];
            end
            st_next.shrink = 4'h0;
          end
        end
        vasfi_pkg::OFS_STATUS: begin
          st_next.rdata[vasfi_pkg::STAT_SHRINK_LSB +: 4] = st_reg.shrink;
          st_next.rdata[vasfi_pkg::STAT_ITALIC_BIT]      = st_reg.italic;
          st_next.rdata[vasfi_pkg::STAT_LOADS_LSB +: 8]  = st_reg.loads;
        end
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end

    // Once per frame the dummy shrinks; past its room the first character goes.
    if (vsync_i && st_reg.scroll_en) begin
      if (shrink_sum > {1'b0, scroll_room}) begin
        st_next.shrink = 4'h0;
        st_next.unlink = 1'b1;
      end else begin
        st_next.shrink = shrink_sum[3:0];
      end
    end

    // Bus clock: dot clock divided by four, realigned during blanking.
    if (hblank_i) begin
      st_next.bus_cnt = 2'h0;
    end else begin
      st_next.bus_cnt = st_reg.bus_cnt + 2'h1;
    end
    st_next.bus_clk = (st_next.bus_cnt < 2'h2);

    // Character clock with a per-character width of four to twelve dots.
    if (hblank_i) begin
      st_next.dot_cnt  = 4'h0;
      st_next.width    = vasfi_pkg::CHAR_MIN_DOTS;
      st_next.italic   = 1'b0;
    end else if (char_end) begin
      st_next.dot_cnt = 4'h0;
      if (char_i.dummy) begin
        st_next.width = dummy_width;
      end else begin
        st_next.width = lut_width;
      end
      if (is_ital_on) begin
        st_next.italic = 1'b1;
      end else if (is_ital_off) begin
        st_next.italic = 1'b0;
      end
      st_next.ser_width = st_next.width;
    end else begin
      st_next.dot_cnt = st_reg.dot_cnt + 4'h1;
    end
    st_next.char_clk = (st_next.dot_cnt < vasfi_pkg::CHAR_HIGH_DOTS);

    // Parallel data: pull-up ones while the clock is high, pixels otherwise.
    if (st_next.char_clk) begin
      st_next.par = 12'hFFF;
    end else if (bitmap_mode) begin
      st_next.par = {4'hF, ~char_i.code};
    end else begin
      st_next.par = {4'hF, font_data_i};
    end
    if (char_i.dummy) begin
      st_next.par[vasfi_pkg::BLANK_FORCE_POS] = 1'b1;
    end

    // Soft font load, once per row, on the dummy's cursor scan line.
    if (hblank_i && scan_line_i == 4'h0) begin
      st_next.row_loaded = 1'b0;
    end
    if (char_end && char_i.dummy && char_i.cursor && !st_reg.row_loaded &&
        !hblank_i) begin
      st_next.fw.we      = 1'b1;
      st_next.fw.addr    = {char_i.code, scan_line_i};
      st_next.fw.data    = row_attr_i[9:2];
      st_next.row_loaded = 1'b1;
      st_next.loads      = st_reg.loads + 8'h01;
    end

    // Video stays at blank level for the whole delayed blank.
    st_next.video = blank_dly ? 1'b1 : ser_video_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg            <= '0;
      st_reg.step       <= vasfi_pkg::CTRL_RST[3:0];
      st_reg.scroll_en  <= vasfi_pkg::CTRL_RST[4];
      st_reg.dummy_full <= vasfi_pkg::DUMMY_FULL_RST;
      st_reg.width      <= vasfi_pkg::CHAR_MIN_DOTS;
      st_reg.ser_width  <= vasfi_pkg::CHAR_MIN_DOTS;
      st_reg.par        <= 12'hFFF;
      st_reg.video      <= 1'b1;
      st_reg.bus_clk    <= 1'b1;
      st_reg.char_clk   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o              = st_reg.ack;
  assign wb_dat_o              = st_reg.rdata;
  assign bus_clock_out_o       = st_reg.bus_clk;
  assign character_clock_out_o = st_reg.char_clk;
  assign ser_width_o           = st_reg.ser_width;
  assign ser_par_o             = st_reg.par;
  assign ser_reverse_o         = 1'b1;
  assign video_o               = st_reg.video;
  assign font_wr_o             = st_reg.fw;
  assign unlink_o              = st_reg.unlink;
  assign italic_o              = st_reg.italic;

endmodule // vasfi_top

// File: hw/vasfi_pkg.sv
// Package with constants and carrier types of the auxiliary video path.
package vasfi_pkg;

  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DUMMY  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Control register fields and reset values.
  localparam int          CTRL_STEP_LSB = 0;
  localparam int          CTRL_EN_BIT   = 4;
  localparam logic [4:0]  CTRL_RST      = 5'h00;
  localparam logic [3:0]  DUMMY_FULL_RST = 4'hC;

  // Status register field positions.
  localparam int STAT_SHRINK_LSB = 0;
  localparam int STAT_ITALIC_BIT = 4;
  localparam int STAT_LOADS_LSB  = 8;

  // Dot clock arithmetic.
  localparam logic [1:0] BUS_DIV_LAST  = 2'h3;
  localparam logic [3:0] CHAR_HIGH_DOTS = 4'h2;
  localparam logic [3:0] CHAR_MIN_DOTS  = 4'h4;
  localparam logic [3:0] CHAR_MAX_DOTS  = 4'hC;
  localparam int         BLANK_STAGES   = 4;
  localparam int         BLANK_FORCE_POS = 11;

  // Italic control characters and their width codes.
  localparam logic [7:0] CODE_BLANK   = 8'h20;
  localparam logic [3:0] W_ITAL_ON9   = 4'h0;
  localparam logic [3:0] W_ITAL_OFF9  = 4'h1;
  localparam logic [3:0] W_ITAL_ON6   = 4'hE;
  localparam logic [3:0] W_ITAL_OFF6  = 4'hF;
  localparam logic [3:0] ITAL_SPLIT9  = 4'h7;
  localparam logic [3:0] ITAL_SPLIT6  = 4'h5;
  localparam logic [3:0] W_NINE       = 4'h9;
  localparam logic [3:0] W_SIX        = 4'h6;

  // Row attribute bit that selects bitmap graphics.
  localparam int ROW_BITMAP_BIT = 1;

  // One character as the controller presents it.
  typedef struct packed {
    logic [7:0] code;
    logic       cursor;
    logic       dummy;
  } vasfi_char_t;

  // One font RAM write.
  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  data;
  } vasfi_font_wr_t;

endpackage

// File: hw/vasfi_dly.sv
// Shift delay line that advances only on a qualifying tick.
module vasfi_dly #(
  parameter int STAGES = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  input  wire logic d_i,
  output logic      q_o
);

  typedef struct packed {
    logic [STAGES-1:0] sr;
  } vasfi_dly_state_t;

  vasfi_dly_state_t st_reg;
  vasfi_dly_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (tick_i) begin
      st_next.sr = {st_reg.sr[STAGES-2:0], d_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.sr[STAGES-1];

endmodule // vasfi_dly

// File: sim/vasfi_assertions.sv
// Concurrent checks on the ports of the auxiliary video path.
module vasfi_assertions (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_ack_o,
  input wire logic                      hblank_i,
  input wire logic                      blank_i,
  input wire logic [9:0]                row_attr_i,
  input wire logic [3:0]                scan_line_i,
  input wire logic                      bus_clock_out_o,
  input wire logic                      character_clock_out_o,
  input wire logic [3:0]                ser_width_o,
  input wire logic [11:0]               ser_par_o,
  input wire logic                      ser_reverse_o,
  input wire logic                      video_o,
  input wire vasfi_pkg::vasfi_font_wr_t font_wr_o,
  input wire logic                      unlink_o,
  input wire logic                      italic_o
);
  logic [4:0] bcnt_reg;
  // Counts how long the raw blank has been high, saturating.
  always_ff @(posedge clk_i) begin
    if (rst_i || !blank_i) bcnt_reg <= 5'h00;
    else if (bcnt_reg != 5'h1F) bcnt_reg <= bcnt_reg + 5'h01;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_reverse_on: assert property (ser_reverse_o)
    else $error("reverse not active");
  a_par_ones: assert property (character_clock_out_o |-> ser_par_o == 12'hFFF)
    else $error("parallel word not all ones");
  a_width_range: assert property (ser_width_o >= 4'h4 && ser_width_o <= 4'hC)
    else $error("width out of range");
  a_bus_div: assert property (@(posedge clk_i) disable iff (rst_i || hblank_i)
    $rose(bus_clock_out_o) |-> ##4 $rose(bus_clock_out_o))
    else $error("bus clock not dot clock over four");
  a_font_pulse: assert property (font_wr_o.we |=> !font_wr_o.we)
    else $error("font write longer than one cycle");
  a_font_data: assert property (font_wr_o.we |-> font_wr_o.data == row_attr_i[9:2]
    && font_wr_o.addr[3:0] == scan_line_i)
    else $error("font write content wrong");
  a_italic_clear: assert property (hblank_i |=> !italic_o)
    else $error("italic kept over row end");
  a_blank_video: assert property (bcnt_reg >= 5'h14 |-> video_o)
    else $error("video not blanked");
  a_unlink_pulse: assert property (unlink_o |=> !unlink_o)
    else $error("unlink longer than one cycle");
endmodule // vasfi_assertions

bind vasfi_top vasfi_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .hblank_i, .blank_i, .row_attr_i, .scan_line_i, .bus_clock_out_o, .character_clock_out_o,
  .ser_width_o, .ser_par_o, .ser_reverse_o, .video_o, .font_wr_o, .unlink_o, .italic_o);

// File: sim/vasfi_partner.sv
// Serializer and font generator model facing the auxiliary video path.
module vasfi_partner (
  input  wire logic        clk_i,
  input  wire logic        char_clk_i,
  input  wire logic [11:0] par_i,
  input  wire logic        reverse_i,
  input  wire logic [3:0]  scan_i,
  output logic      [7:0]  font_data_o,
  output logic             video_o
);
  logic [11:0] sh_reg = 12'hFFF;
  logic        cc_reg = 1'b1;
  // The font outputs float while the character clock is high; pull-ups give ones.
  assign font_data_o = char_clk_i ? 8'hFF : {scan_i, ~scan_i};
  always_ff @(posedge clk_i) begin
    cc_reg <= char_clk_i;
    if (cc_reg && !char_clk_i) sh_reg <= par_i;
    else sh_reg <= {sh_reg[10:0], 1'b1};
  end
  // A one is a blank pixel, so reverse turns stored ones into dark video.
  assign video_o = reverse_i ? ~sh_reg[11] : sh_reg[11];
endmodule // vasfi_partner

// File: sim/tb_vasfi_top.sv
// Self-checking bench for the auxiliary video path.
module tb_vasfi_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic hblank_i = 1'b0, vsync_i = 1'b0, blank_i = 1'b0, ser_video_i;
  logic [7:0]  wb_adr_i = 8'h00, font_data_i;
  logic [3:0]  wb_sel_i = 4'h0, scan_line_i = 4'h0, ratio_i = 4'h9, ser_width_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [9:0]  row_attr_i = 10'h000;
  logic [11:0] ser_par_o;
  logic        wb_ack_o, bus_clock_out_o, character_clock_out_o, ser_reverse_o;
  logic        video_o, unlink_o, italic_o;
  vasfi_pkg::vasfi_char_t   char_i = '0;
  vasfi_pkg::vasfi_font_wr_t font_wr_o, last_wr;
  int fails = 0, cmp_count = 0, cycles = 0, wr_count = 0, unl_count = 0;
  // Entries: ratio, scan line, expected width, expected italic state.
  localparam logic [12:0] TBL [13] = '{{4'h9, 4'h0, 4'h9, 1'b0}, {4'h4, 4'h3, 4'h4, 1'b0},
    {4'hC, 4'h3, 4'hC, 1'b0}, {4'h0, 4'h3, 4'hA, 1'b1}, {4'h0, 4'h9, 4'h8, 1'b1},
    {4'h1, 4'h3, 4'h8, 1'b0}, {4'h1, 4'h9, 4'hA, 1'b0}, {4'hE, 4'h2, 4'h7, 1'b1},
    {4'hE, 4'h8, 4'h5, 1'b1}, {4'hF, 4'h2, 4'h5, 1'b0}, {4'hF, 4'h8, 4'h7, 1'b0},
    {4'h2, 4'h0, 4'hC, 1'b0}, {4'hD, 4'h0, 4'hC, 1'b0}};

  vasfi_top u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .hblank_i, .vsync_i, .blank_i, .char_i, .row_attr_i,
    .scan_line_i, .ratio_i, .font_data_i, .ser_video_i, .bus_clock_out_o,
    .character_clock_out_o, .ser_width_o, .ser_par_o, .ser_reverse_o, .video_o,
    .font_wr_o, .unlink_o, .italic_o);
  vasfi_partner u_partner (.clk_i, .char_clk_i(character_clock_out_o), .par_i(ser_par_o),
    .reverse_i(ser_reverse_o), .scan_i(scan_line_i), .font_data_o(font_data_i),
    .video_o(ser_video_i));

  initial forever #12.5 clk_i = ~clk_i;

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (font_wr_o.we === 1'b1) begin
      wr_count <= wr_count + 1;
      last_wr <= font_wr_o;
    end
    if (unlink_o === 1'b1) unl_count <= unl_count + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(n, e, rd);
  endtask

  // Waits into the low phase of the character clock, past its first dot.
  task automatic par_low();
    do @(posedge clk_i); while (character_clock_out_o !== 1'b0);
    @(posedge clk_i);
  endtask

  task automatic pulse_hblank();
    @(posedge clk_i);
    hblank_i <= 1'b1;
    cyc(8);
    hblank_i <= 1'b0;
  endtask

  initial begin
    cyc(6);
    chk("reset outs", 23'h13FFE3, {wb_ack_o, ser_width_o, ser_par_o, video_o, font_wr_o.we,
      italic_o, unlink_o, bus_clock_out_o, character_clock_out_o});
    rst_i <= 1'b0;
    rdchk("ctrl", vasfi_pkg::OFS_CTRL, 32'h0);
    rdchk("dummy", vasfi_pkg::OFS_DUMMY, 32'hC);
    rdchk("status", vasfi_pkg::OFS_STATUS, 32'h0);
    rdchk("unmapped", 8'h0C, 32'h0);
    wb(1'b1, vasfi_pkg::OFS_DUMMY, 32'h3, 4'hF);
    rdchk("dummy low", vasfi_pkg::OFS_DUMMY, 32'hC);
    wb(1'b1, vasfi_pkg::OFS_DUMMY, 32'h8, 4'h0);
    rdchk("dummy sel", vasfi_pkg::OFS_DUMMY, 32'hC);
    wb(1'b1, vasfi_pkg::OFS_STATUS, 32'hFF, 4'hF);
    rdchk("status ro", vasfi_pkg::OFS_STATUS, 32'h0);
    // Scrolling by three per frame; a dummy without cursor never loads the font.
    char_i <= '{code: 8'h41, cursor: 1'b0, dummy: 1'b1};
    wb(1'b1, vasfi_pkg::OFS_CTRL, 32'h13, 4'hF);
    for (int i = 1; i <= 3; i++) begin
      @(posedge clk_i);
      vsync_i <= 1'b1;
      @(posedge clk_i);
      vsync_i <= 1'b0;
      cyc(40);
      chk("dummy width", 32'hC - (i < 3 ? 3 * i : 0), ser_width_o);
      rdchk("shrink", vasfi_pkg::OFS_STATUS, i < 3 ? 3 * i : 0);
    end
    chk("unlinks", 32'h1, unl_count);
    chk("no cursor load", 32'h0, wr_count);
    wb(1'b1, vasfi_pkg::OFS_CTRL, 32'h0, 4'hF);
    // Font slice load from a dummy with cursor set, held over several dummies.
    pulse_hblank();
    scan_line_i <= 4'h5;
    row_attr_i  <= {8'hA5, 2'b00};
    char_i      <= '{code: 8'h41, cursor: 1'b1, dummy: 1'b1};
    cyc(80);
    chk("loads per row", 32'h1, wr_count);
    chk("font addr", {8'h41, 4'h5}, last_wr.addr);
    chk("font data", 32'hA5, last_wr.data);
    rdchk("load count", vasfi_pkg::OFS_STATUS, 32'h100);
    char_i <= '{code: 8'h20, cursor: 1'b0, dummy: 1'b0};
    for (int i = 0; i < 13; i++) begin
      ratio_i     <= TBL[i][12:9];
      scan_line_i <= TBL[i][8:5];
      cyc(40);
      chk("width", TBL[i][4:1], ser_width_o);
      chk("italic", TBL[i][0], italic_o);
    end
    ratio_i <= 4'hE;
    cyc(40);
    pulse_hblank();
    cyc(2);
    chk("italic row end", 32'h0, italic_o);
    // Bitmap rows feed the inverted code; font rows feed the generator pixels.
    ratio_i    <= 4'h9;
    scan_line_i <= 4'h0;
    row_attr_i <= 10'h002;
    char_i     <= '{code: 8'h3C, cursor: 1'b0, dummy: 1'b0};
    cyc(30);
    par_low();
    chk("bitmap par", 32'hFC3, ser_par_o);
    row_attr_i <= 10'h000;
    cyc(30);
    par_low();
    chk("font par", 32'hF0F, ser_par_o);
    blank_i <= 1'b1;
    cyc(24);
    chk("blanked video", 32'h1, video_o);
    blank_i <= 1'b0;
    cyc(24);
    final_report();
  end
endmodule // tb_vasfi_top
